// >>> hw/tbu_timer.v
// Timer B unit: counter, prescaler, modulo and four compare/PWM channels
// with buffered pairs 0/1 and 2/3. Register port with one-cycle reads.
// Assumes all inputs synchronous to i_core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "tbu_map.vh"

// Operation
// - Link bit two pairs channels two, three
// - Second channel write takes over at overflow
// - Linked higher channel control unused, pin released
// - Pin toggles at modulo overflow
// - Pulse width is overflow to compare
// - Modulo 255 divide one gives 256 periods
// - Compare 128 gives half duty
// - Unbuffered rewrite may miss a compare
// - Link bit zero pairs channels zero, one
// - Buffered width changes at period start
// - Lower channel control governs linked output
// - Mode pair 0:1 unbuffered, 1:0 buffered
// - Compare drives complement of pulse level
// - Link bit overrides lower mode bit
// - Clear toggle bit with compare-clear action gives zero duty
// - Full duty bit, no toggle, 100 percent
// - Overflow when counter wraps after modulo
// - Clear bit resets counter and prescaler
// - Prescale divides by power of two or external
module tbu_timer #(
  parameter CH_N = 4,          // Channel count
  parameter PS_W = 6           // Prescaler counter width
) (
  input wire i_core_clk,       // Core clock, 125 MHz
  input wire i_rstn,           // Synchronous reset, active low
  input wire [4:0] i_addr,     // Register address
  input wire [15:0] i_wdata,   // Write data
  input wire i_wr,             // Write strobe
  input wire i_rd,             // Read strobe
  input wire i_ext_clk,        // External count clock pin level
  output reg [15:0] o_rdata_reg, // Read data, cycle after read
  output wire [3:0] o_pin,     // Channel pin levels
  output wire [3:0] o_pin_oe_n, // Channel pin drive enables, low drives
  output reg o_ovf_pulse_reg,  // Overflow event pulse
  output wire [3:0] o_match    // Per-channel compare match pulses
);

  reg [7:0] status_reg;
  reg [15:0] count_reg;
  reg [15:0] modulo_value_reg;
  reg [PS_W-1:0] ps_reg;
  reg ext_d_reg;
  reg [7:0] ctrl_reg [0:CH_N-1];
  reg [15:0] cmp_reg [0:CH_N-1];
  reg use_hi0_reg;
  reg use_hi2_reg;
  reg pend0_reg;
  reg pend2_reg;
  reg ovf_flag_armed_reg;
  reg ovf_read_seen_reg;
  reg [3:0] chan_flag_set;

  wire link_enable_ch0 = ctrl_reg[0][`TBU_CH_MODE_HI];
  wire link_enable_ch2 = ctrl_reg[2][`TBU_CH_MODE_HI];
  wire counter_halt = status_reg[`TBU_ST_HALT];
  wire [2:0] prescale_select = status_reg[`TBU_ST_PS_HI:`TBU_ST_PS_LO];
  wire tick;
  wire ovf;
  wire [15:0] gov_cmp [0:CH_N-1];
  wire [CH_N-1:0] ch_en;
  wire [CH_N-1:0] match;
  wire [CH_N-1:0] pin_w;

  // Decode: does an offset hit one of the channel control registers
  function is_ctrl;
    input [4:0] a;
    begin
      is_ctrl = (a >= `TBU_OFS_CTRL0) && (a <= `TBU_OFS_CTRL3);
    end
  endfunction

  function is_cmp;
    input [4:0] a;
    begin
      is_cmp = (a >= `TBU_OFS_CMP0) && (a <= `TBU_OFS_CMP3);
    end
  endfunction

  // Prescaler tap or external rising edge
  reg tick_sel;
  always @* begin
    tick_sel = 1'b0;
    if (prescale_select == `TBU_PS_EXT) begin
      tick_sel = i_ext_clk && !ext_d_reg;
    end else if (prescale_select == 3'h0) begin
      tick_sel = 1'b1;
    end else begin
      tick_sel = (ps_reg[prescale_select - 3'h1 +: 1] == 1'b1) &&
        (ps_reg & ((6'h01 << prescale_select) - 6'h01)) ==
        ((6'h01 << prescale_select) - 6'h01);
    end
  end

  wire clr_wr = i_wr && (i_addr == `TBU_OFS_STATUS) &&
    i_wdata[`TBU_ST_CLR];
  assign tick = !counter_halt && !clr_wr && tick_sel;
  assign ovf = tick && (count_reg == modulo_value_reg);

  // Value the counter reaches on this tick; a match is the counter reaching
  // the compare value, so compare 128 of 256 gives exactly half duty
  wire [15:0] cnt_next = ovf ? `TBU_CNT_RESET : count_reg + 16'h0001;

  // Counter, prescaler and clear
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      count_reg <= `TBU_CNT_RESET;
      ps_reg <= {PS_W{1'b0}};
      ext_d_reg <= 1'b0;
      o_ovf_pulse_reg <= 1'b0;
    end else begin
      ext_d_reg <= i_ext_clk;
      o_ovf_pulse_reg <= ovf;
      if (clr_wr) begin
        count_reg <= `TBU_CNT_RESET;
        ps_reg <= {PS_W{1'b0}};
      end else begin
        if (!counter_halt) begin
          ps_reg <= ps_reg + {{(PS_W-1){1'b0}}, 1'b1};
        end
        if (ovf) begin
          count_reg <= `TBU_CNT_RESET;
        end else if (tick) begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end

  // Buffered pair selection; link beats low mode bit
  assign gov_cmp[0] = (link_enable_ch0 && use_hi0_reg) ? cmp_reg[1] :
    cmp_reg[0];
  assign gov_cmp[1] = cmp_reg[1];
  assign gov_cmp[2] = (link_enable_ch2 && use_hi2_reg) ? cmp_reg[3] :
    cmp_reg[2];
  assign gov_cmp[3] = cmp_reg[3];

  // Higher channel idles while linked; its pin is released
  assign ch_en[0] = ctrl_reg[0][`TBU_CH_MODE_HI] |
    ctrl_reg[0][`TBU_CH_MODE_LO];
  assign ch_en[1] = !link_enable_ch0 &&
    ctrl_reg[1][`TBU_CH_MODE_LO];
  assign ch_en[2] = ctrl_reg[2][`TBU_CH_MODE_HI] |
    ctrl_reg[2][`TBU_CH_MODE_LO];
  assign ch_en[3] = !link_enable_ch2 && ctrl_reg[3][`TBU_CH_MODE_LO];

  genvar g;
  generate
    for (g = 0; g < CH_N; g = g + 1) begin : g_ch
      tbu_channel u_ch (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_tick(tick),
        .i_ovf(ovf),
        .i_count(cnt_next),
        .i_cmp(gov_cmp[g]),
        .i_enable(ch_en[g]),
        .i_els(ctrl_reg[g][`TBU_CH_ELS_HI:`TBU_CH_ELS_LO]),
        .i_tov(ctrl_reg[g][`TBU_CH_TOV]),
        .i_max(ctrl_reg[g][`TBU_CH_MAX]),
        .o_match(match[g]),
        .o_pin_reg(pin_w[g])
      );
      assign o_pin_oe_n[g] = !ch_en[g];
    end
  endgenerate

  assign o_pin = pin_w;
  assign o_match = match;

  // Pending buffer swap, applied at overflow
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      use_hi0_reg <= 1'b0;
      use_hi2_reg <= 1'b0;
      pend0_reg <= 1'b0;
      pend2_reg <= 1'b0;
    end else begin
      if (!link_enable_ch0) begin
        use_hi0_reg <= 1'b0;
        pend0_reg <= 1'b0;
      end else begin
        if (ovf) begin
          use_hi0_reg <= pend0_reg;
        end
        if (i_wr && i_addr == `TBU_OFS_CMP1) begin
          pend0_reg <= 1'b1;
        end else if (i_wr && i_addr == `TBU_OFS_CMP0) begin
          pend0_reg <= 1'b0;
        end
      end
      if (!link_enable_ch2) begin
        use_hi2_reg <= 1'b0;
        pend2_reg <= 1'b0;
      end else begin
        if (ovf) begin
          use_hi2_reg <= pend2_reg;
        end
        if (i_wr && i_addr == `TBU_OFS_CMP3) begin
          pend2_reg <= 1'b1;
        end else if (i_wr && i_addr == `TBU_OFS_CMP2) begin
          pend2_reg <= 1'b0;
        end
      end
    end
  end

  // Channel flags are credited to the lower channel while linked
  always @* begin
    chan_flag_set = match;
    if (link_enable_ch0) begin
      chan_flag_set[1] = 1'b0;
    end
    if (link_enable_ch2) begin
      chan_flag_set[3] = 1'b0;
    end
  end

  // Registers. Overflow flag clears by read-then-write-0, channel flags by write-0 alone; a set wins.
  integer k;
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      status_reg <= `TBU_ST_RESET;
      modulo_value_reg <= `TBU_MOD_RESET;
      ovf_read_seen_reg <= 1'b0;
      ovf_flag_armed_reg <= 1'b0;
      for (k = 0; k < CH_N; k = k + 1) begin
        ctrl_reg[k] <= `TBU_CH_RESET;
        cmp_reg[k] <= `TBU_CMP_RESET;
      end
    end else begin
      if (i_rd && i_addr == `TBU_OFS_STATUS &&
          status_reg[`TBU_ST_OVF]) begin
        ovf_read_seen_reg <= 1'b1;
      end
      if (i_wr && i_addr == `TBU_OFS_STATUS) begin
        status_reg[`TBU_ST_OVIE] <= i_wdata[`TBU_ST_OVIE];
        status_reg[`TBU_ST_HALT] <= i_wdata[`TBU_ST_HALT];
        status_reg[`TBU_ST_PS_HI:`TBU_ST_PS_LO] <=
          i_wdata[`TBU_ST_PS_HI:`TBU_ST_PS_LO];
        if (!i_wdata[`TBU_ST_OVF] && ovf_read_seen_reg) begin
          status_reg[`TBU_ST_OVF] <= 1'b0;
          ovf_read_seen_reg <= 1'b0;
        end
      end
      if (ovf) begin
        status_reg[`TBU_ST_OVF] <= 1'b1;
      end
      if (i_wr && i_addr == `TBU_OFS_MOD) begin
        modulo_value_reg <= i_wdata;
      end
      for (k = 0; k < CH_N; k = k + 1) begin
        if (i_wr && is_ctrl(i_addr) &&
            i_addr[1:0] == k[1:0]) begin
          ctrl_reg[k][6:0] <= i_wdata[6:0];
          if (!i_wdata[`TBU_CH_FLAG]) begin
            ctrl_reg[k][`TBU_CH_FLAG] <= 1'b0;
          end
        end
        if (chan_flag_set[k]) begin
          ctrl_reg[k][`TBU_CH_FLAG] <= 1'b1;
        end
        if (i_wr && is_cmp(i_addr) && i_addr[1:0] == k[1:0]) begin
          cmp_reg[k] <= i_wdata;
        end
      end
    end
  end

  // Read data, valid in the cycle after the strobe
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_rdata_reg <= 16'h0000;
    end else if (i_rd) begin
      if (i_addr == `TBU_OFS_STATUS) begin
        o_rdata_reg <= {8'h00, status_reg & ~(8'h01 << `TBU_ST_CLR)};
      end else if (i_addr == `TBU_OFS_CNT) begin
        o_rdata_reg <= count_reg;
      end else if (i_addr == `TBU_OFS_MOD) begin
        o_rdata_reg <= modulo_value_reg;
      end else if (is_ctrl(i_addr)) begin
        o_rdata_reg <= {8'h00, ctrl_reg[i_addr[1:0]]};
      end else if (is_cmp(i_addr)) begin
        o_rdata_reg <= cmp_reg[i_addr[1:0]];
      end else begin
        o_rdata_reg <= 16'h0000;
      end
    end else begin
      o_rdata_reg <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// >>> hw/tbu_map.vh
// Constants for the timer B unit: register offsets, field positions,
// reset values and encodings. Definitions only.
`ifndef TBU_MAP_VH
`define TBU_MAP_VH

// Register offsets on the plain register port
`define TBU_OFS_STATUS   5'h00
`define TBU_OFS_CNT      5'h01
`define TBU_OFS_MOD      5'h02
`define TBU_OFS_CTRL0    5'h04
`define TBU_OFS_CTRL1    5'h05
`define TBU_OFS_CTRL2    5'h06
`define TBU_OFS_CTRL3    5'h07
`define TBU_OFS_CMP0     5'h08
`define TBU_OFS_CMP1     5'h09
`define TBU_OFS_CMP2     5'h0A
`define TBU_OFS_CMP3     5'h0B

// Timer status/control fields
`define TBU_ST_OVF       7
`define TBU_ST_OVIE      6
`define TBU_ST_HALT      5
`define TBU_ST_CLR       4
`define TBU_ST_PS_HI     2
`define TBU_ST_PS_LO     0
`define TBU_ST_RESET     8'h20

// Channel control fields
`define TBU_CH_FLAG      7
`define TBU_CH_IE        6
`define TBU_CH_MODE_HI   5
`define TBU_CH_MODE_LO   4
`define TBU_CH_ELS_HI    3
`define TBU_CH_ELS_LO    2
`define TBU_CH_TOV       1
`define TBU_CH_MAX       0
`define TBU_CH_RESET     8'h00

// Prescaler code that selects the external count clock
`define TBU_PS_EXT       3'h7
// Compare action pair codes
`define TBU_ELS_TOGGLE   2'h1
`define TBU_ELS_CLEAR    2'h2
`define TBU_ELS_SET      2'h3

`define TBU_CNT_RESET    16'h0000
`define TBU_CMP_RESET    16'h0000
`define TBU_MOD_RESET    16'hFFFF

`endif

// >>> hw/tbu_channel.v
// One output compare / PWM channel of the timer B unit.
// Assumes the caller supplies the governing compare value and a tick.
`timescale 1ns/1ns
`default_nettype none
`include "tbu_map.vh"

module tbu_channel (
  input wire i_core_clk,       // Core clock
  input wire i_rstn,           // Synchronous reset, active low
  input wire i_tick,           // Counter advanced this cycle
  input wire i_ovf,            // Overflow event on this tick
  input wire [15:0] i_count,   // Counter value after the tick
  input wire [15:0] i_cmp,     // Governing compare value
  input wire i_enable,         // Channel drives its pin
  input wire [1:0] i_els,      // Edge/level select pair
  input wire i_tov,            // Toggle on overflow
  input wire i_max,            // Full duty force
  output wire o_match,         // Compare match pulse
  output reg o_pin_reg         // Pin level
);

  reg pin_next;

  assign o_match = i_tick && i_enable && (i_count == i_cmp);

  always @* begin
    pin_next = o_pin_reg;
    if (i_enable) begin
      if (i_max && !i_tov) begin
        pin_next = 1'b1;
      end else begin
        if (o_match) begin
          case (i_els)
            `TBU_ELS_TOGGLE: pin_next = ~pin_next;
            `TBU_ELS_CLEAR: pin_next = 1'b0;
            `TBU_ELS_SET: pin_next = 1'b1;
            default: pin_next = o_pin_reg;
          endcase
        end
        // Toggle only when enabled; a clear toggle bit with compare-clear holds 0%
        if (i_ovf && i_tov) begin
          pin_next = ~o_pin_reg;
        end
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_pin_reg <= 1'b0;
    end else begin
      o_pin_reg <= pin_next;
    end
  end

endmodule
`default_nettype wire

// >>> sim/tbu_chk.sv
// Assertion checker for the timer B unit top-level ports.
// Bound to tbu_timer; channel 2 control is shadowed from the bus.
`timescale 1ns/1ns
`default_nettype none
module tbu_chk (
  input wire logic i_core_clk, // Clock
  input wire logic i_rstn, // Reset, low
  input wire logic [4:0] i_addr, // Address
  input wire logic [15:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic i_ext_clk, // Ext clock
  input wire logic [15:0] o_rdata_reg, // Read data
  input wire logic [3:0] o_pin, // Pins
  input wire logic [3:0] o_pin_oe_n, // Pin enables
  input wire logic o_ovf_pulse_reg, // Overflow
  input wire logic [3:0] o_match // Matches
);
  reg [7:0] sh2_reg;
  wire en2 = sh2_reg[5:4] != 2'h0;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  always @(posedge i_core_clk) begin
    if (!i_rstn)
      sh2_reg <= 8'h00;
    else if (i_wr && i_addr == 5'h06)
      sh2_reg <= i_wdata[7:0];
  end
  a_clr_reads0: assert property (i_rd && i_addr == 5'h00
    |=> !o_rdata_reg[4]) else $error("clear bit read as one");
  a_clr_count: assert property (
    i_wr && i_addr == 5'h00 && i_wdata[5:4] == 2'h3
    ##[1:2] i_rd && i_addr == 5'h01 |=> o_rdata_reg == 16'h0000)
    else $error("count not zero after clear");
  a_link0_free: assert property (
    i_wr && i_addr == 5'h04 && i_wdata[5] |=> o_pin_oe_n[1:0] == 2'h2)
    else $error("pair 0 pins wrong");
  a_link2_free: assert property (
    i_wr && i_addr == 5'h06 && i_wdata[5] |=> o_pin_oe_n[3:2] == 2'h2)
    else $error("pair 2 pins wrong");
  a_ovf_toggle: assert property (o_ovf_pulse_reg && $past(en2)
    && $past(sh2_reg[1:0]) == 2'h2 |-> o_pin[2] != $past(o_pin[2]))
    else $error("no toggle on overflow");
  a_zero_duty: assert property ($past(en2)
    && $past(sh2_reg[3:0]) == 4'h8 |-> !$rose(o_pin[2]))
    else $error("pin rose at zero duty");
  a_full_duty: assert property ($past(en2)
    && $past(sh2_reg[1:0]) == 2'h1 |-> o_pin[2])
    else $error("pin low at full duty");
  a_cmp_clear: assert property (o_match[2] && en2
    && sh2_reg[3:2] == 2'h2 && !sh2_reg[0]
    |=> !o_pin[2] || o_ovf_pulse_reg) else $error("compare did not clear");
  a_cmp_set: assert property (o_match[2] && en2
    && sh2_reg[3:2] == 2'h3 && !sh2_reg[0]
    |=> o_pin[2] || o_ovf_pulse_reg) else $error("compare did not set");
  c_ovf: cover property (o_ovf_pulse_reg);
  c_match: cover property (o_match[2] && en2);
  c_full: cover property ($past(sh2_reg[1:0]) == 2'h1 && o_pin[2]);
endmodule
bind tbu_timer tbu_chk tbu_chk_inst (.i_core_clk(i_core_clk),
  .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .i_ext_clk(i_ext_clk), .o_rdata_reg(o_rdata_reg),
  .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
  .o_ovf_pulse_reg(o_ovf_pulse_reg), .o_match(o_match));
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the timer B unit.
// Assumes a 125 MHz core clock; drives the register port directly.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [4:0] addr = 5'h00;
  reg [15:0] wd = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg ext = 1'b0;
  reg [1:0] ediv = 2'h0;
  wire [15:0] rdata;
  wire [3:0] pin;
  wire [3:0] oe_n;
  wire [3:0] mt;
  wire ovf;
  wire [4:0] mon = {ovf, pin};
  integer n_fail = 0;
  integer checked = 0;
  always #4 clk = ~clk;
  // External count clock rises every 8 core cycles
  always @(posedge clk) begin
    ediv <= ediv + 2'h1;
    if (ediv == 2'h3)
      ext <= ~ext;
  end
  tbu_timer tbu_timer_inst (.i_core_clk(clk), .i_rstn(rstn),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_ext_clk(ext),
    .o_rdata_reg(rdata), .o_pin(pin), .o_pin_oe_n(oe_n),
    .o_ovf_pulse_reg(ovf), .o_match(mt));
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task cmp(input [15:0] g, input [15:0] e, input [63:0] m);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t %0s got %h exp %h", $time, m, g, e);
      end
    end
  endtask
  task wreg(input [4:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [4:0] a, output [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
    end
  endtask
  // Waits at falling edges until the watched bit equals v
  task till(input integer b, input v, output integer n);
    begin
      n = 0;
      @(negedge clk);
      while (mon[b] !== v && n < 2000) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 2000) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t wait timed out", $time);
        wrap_up;
      end
    end
  endtask
  // Syncs on a real rising edge, then measures one high and one low phase
  task pw(input integer b, output integer hi, output integer lo);
    integer t;
    begin
      till(b, 1'b0, t);
      till(b, 1'b1, t);
      till(b, 1'b0, hi);
      till(b, 1'b1, lo);
      hi = hi + 1;
      lo = lo + 1;
    end
  endtask
  task cnt(input integer b, input v, output integer k);
    integer j;
    begin
      k = 0;
      for (j = 0; j < 256; j = j + 1) begin
        @(negedge clk);
        if (mon[b] === v)
          k = k + 1;
      end
    end
  endtask
  task setup(input [4:0] c, input [15:0] w, input [7:0] ctl);
    begin
      wreg(5'h00, 16'h0030);
      wreg(5'h02, 16'h00FF);
      wreg(c + 5'h08, w);
      wreg(c + 5'h04, {8'h00, ctl});
      wreg(5'h00, 16'h0000);
    end
  endtask
  task t_reset;
    reg [15:0] d;
    integer i;
    begin
      cmp(oe_n, 16'h000F, "oe");
      wreg(5'h1F, 16'hFFFF);
      for (i = 0; i < 12; i = i + 1) begin
        rreg(i[4:0], d);
        cmp(d, i == 0 ? 16'h0020 : i == 2 ? 16'hFFFF : 16'h0000, "reset");
      end
      $display("reset test done");
    end
  endtask
  task t_pwm;
    integer h, l;
    begin
      setup(5'h02, 16'h0080, 8'h1A);
      pw(2, h, l);
      cmp(h, 16'h0080, "high");
      cmp(h + l, 16'h0100, "period");
      cmp(oe_n[2], 16'h0000, "oe");
      wreg(5'h0A, 16'h00A0);
      till(2, 1'b0, h);
      cmp(h + 2, 16'h00A0, "long");
      wreg(5'h0A, 16'h0060);
      pw(2, h, l);
      cmp(h, 16'h0060, "short");
      setup(5'h02, 16'h0040, 8'h1E);
      pw(2, h, l);
      cmp(h, 16'h00C0, "set");
      $display("pwm test done");
    end
  endtask
  task t_zf;
    integer k;
    begin
      setup(5'h02, 16'h0080, 8'h18);
      repeat (300) @(negedge clk);
      cnt(2, 1'b1, k);
      cmp(k, 16'h0000, "zero");
      wreg(5'h06, 16'h0019);
      repeat (2) @(negedge clk);
      cnt(2, 1'b0, k);
      cmp(k, 16'h0000, "full");
      $display("duty test done");
    end
  endtask
  task t_buf(input [4:0] c, input [7:0] ctl);
    integer h, l, t;
    begin
      setup(c, 16'h0040, ctl);
      wreg(c + 5'h05, 16'h001A);
      cmp(oe_n[c + 5'h01], 16'h0001, "free");
      pw(c, h, l);
      cmp(h, 16'h0040, "first");
      wreg(c + 5'h09, 16'h0020);
      till(c, 1'b0, t);
      cmp(t + 2, 16'h0040, "hold");
      pw(c, h, l);
      cmp(h, 16'h0020, "next");
      wreg(c + 5'h08, 16'h0030);
      till(c, 1'b0, t);
      pw(c, h, l);
      cmp(h, 16'h0030, "back");
      $display("buffered test done");
    end
  endtask
  task t_cnt;
    reg [15:0] d;
    integer i, h, l;
    begin
      wreg(5'h00, 16'h0030);
      rreg(5'h01, d);
      cmp(d, 16'h0000, "clear");
      rreg(5'h00, d);
      cmp(d & 16'h007F, 16'h0020, "status");
      wreg(5'h02, 16'h000F);
      for (i = 0; i < 5; i = i + 1) begin
        wreg(5'h00, 16'h0010 | (i < 4 ? i[15:0] : 16'h0007));
        pw(4, h, l);
        cmp(h + l, i < 4 ? 16'h0010 << i : 16'h0080, "rate");
      end
      $display("counter test done");
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_pwm;
    t_zf;
    t_buf(5'h00, 8'h3A);
    t_buf(5'h02, 8'h2A);
    t_cnt;
    wrap_up;
  end
endmodule
`default_nettype wire
